/* transceiver_reset_lock_control_tb.sv */
// Self-checking bench for the reset and lock control pair
`timescale 1ns/10ps
module transceiver_reset_lock_control_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, seq_done;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, wd;
   logic [3:0] tx_pcs_reset, rx_pcs_reset, cdr_reset;
   logic cmu_pll_off, tx_buffer_off, rx_buffer_off, deser_off, offset_cancel_active, cfg_error, e;
   int fails = 0;
   int tests_run = 0;
   trlc_if lnk_if();
   trlc_xcvr trlc_xcvr_inst (.pclk, .presetn, .lnk(lnk_if), .tx_pcs_reset, .rx_pcs_reset, .cdr_reset, .cmu_pll_off,
      .tx_buffer_off, .rx_buffer_off, .deser_off, .offset_cancel_active, .cfg_error);
   trlc_ctl trlc_ctl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .seq_done, .lnk(lnk_if));
   trlc_assertions trlc_assertions_inst (.pclk, .presetn, .busy(lnk_if.busy), .cfg_has_rx(lnk_if.cfg_has_rx),
      .cfg_manual_lock(lnk_if.cfg_manual_lock), .cfg_bonded(lnk_if.cfg_bonded), .cfg_mode(lnk_if.cfg_mode),
      .pll_powerdown(lnk_if.pll_powerdown), .pll_locked(lnk_if.pll_locked),
      .tx_digital_reset(lnk_if.tx_digital_reset), .rx_analog_reset(lnk_if.rx_analog_reset),
      .reference_lock_mode(lnk_if.reference_lock_mode), .data_lock_mode(lnk_if.data_lock_mode),
      .rx_freqlocked(lnk_if.rx_freqlocked));
   // ====
   // Tasks
   task chk(input logic [31:0] s, input logic [31:0] x);
   begin
      tests_run++;
      if (s !== x)
      begin
         fails++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
      end
   end
   endtask
   task close_out;
   begin
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
   begin
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {q, e} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   end
   endtask
   // Bounded: a stuck sequence must not hang the run
   task wait_done;
      int n;
   begin
      n = 0;
      @(posedge pclk);
      while (seq_done !== 1'b1 && n < 3000)
      begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, seq_done}, 32'h0000_0001);
   end
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial
   begin
      repeat (40000) @(posedge pclk);
      fails++;
      close_out;
   end
   // ====
   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      q = $urandom(32'hb6004fa5);
      apb(1'b0, 12'h000, 32'h0);
      chk(q, trlc_pkg::CTRL_RESET);
      repeat (4)
      begin
         wd = $urandom & 32'hffff_ffce;
         apb(1'b1, 12'h000, wd);
         apb(1'b0, 12'h000, 32'h0);
         chk(q, wd & 32'h0000_004e);
      end
      apb(1'b0, 12'h008, 32'h0);
      chk(q, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0001);
      apb(1'b1, 12'h000, 32'h0000_0040);
      repeat (3) @(posedge pclk);
      chk({cmu_pll_off, tx_buffer_off, rx_buffer_off, deser_off, tx_pcs_reset & cdr_reset}, 8'hff);
      apb(1'b1, 12'h000, 32'h0000_0001);
      wait_done;
      chk({tx_pcs_reset, rx_pcs_reset, offset_cancel_active, cmu_pll_off}, 10'h03c);
      for (int m = 0; m < 6; m++)
      begin
         apb(1'b1, 12'h000, 32'h3 | ((m & 1) << 2) | ((m >> 1) << 4));
         wait_done;
         chk({rx_pcs_reset, cdr_reset}, 8'h00);
         chk({offset_cancel_active, cfg_error}, 2'h2);
         apb(1'b0, 12'h004, 32'h0);
         chk({q[16:8], q[3]}, 10'h201);
      end
      close_out;
   end
endmodule

/* trlc_assertions.sv */
// Link checker for the reset and lock control pair
`timescale 1ns/10ps
module trlc_assertions (
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic                        busy,
   input wire logic                        cfg_has_rx,
   input wire logic                        cfg_manual_lock,
   input wire logic                        cfg_bonded,
   input wire logic [1:0]                  cfg_mode,
   input wire logic                        pll_powerdown,
   input wire logic                        pll_locked,
   input wire logic [trlc_pkg::NUM_CH-1:0] tx_digital_reset,
   input wire logic [trlc_pkg::NUM_CH-1:0] rx_analog_reset,
   input wire logic [trlc_pkg::NUM_CH-1:0] reference_lock_mode,
   input wire logic [trlc_pkg::NUM_CH-1:0] data_lock_mode,
   input wire logic [trlc_pkg::NUM_CH-1:0] rx_freqlocked
);
   // ====
   // Busy run length; lane 0 stands for all, bonded fan-out
   logic [7:0] run_reg;
   logic       seen_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_reg  <= 8'h00;
         seen_reg <= 1'b0;
      end
      else
      begin
         run_reg  <= busy ? run_reg + 8'h01 : 8'h00;
         seen_reg <= seen_reg | (run_reg != 8'h00 && !busy);
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ====
   // Properties
   chk_busy_first_low: assert property ($rose(presetn) |-> !busy) else $error("busy high in first cycle");
   chk_busy_needs_rx: assert property ($rose(busy) |-> cfg_has_rx) else $error("busy without receiver");
   chk_busy_run_len: assert property ($fell(busy) |-> run_reg == 8'h40) else $error("busy run length");
   chk_ana_after_busy: assert property ($fell(rx_analog_reset[0]) |-> seen_reg) else $error("early analog release");
   chk_ana_pulse_min: assert property ($rose(rx_analog_reset[0]) |=> rx_analog_reset[0])
      else $error("analog reset pulse short");
   chk_xaui_bonded: assert property (cfg_mode == 2'h1 |-> cfg_bonded) else $error("xaui not bonded");
   chk_pll_down_unlocked: assert property (pll_powerdown |=> !pll_locked) else $error("pll locked in power-down");
   chk_tx_after_lock: assert property ($fell(tx_digital_reset[0]) |-> pll_locked) else $error("tx release early");
   chk_data_lock_freq: assert property ((cfg_has_rx && cfg_manual_lock && cfg_mode != 2'h2 && data_lock_mode[0]
      && !rx_analog_reset[0]) [*2] |-> rx_freqlocked[0]) else $error("no freq lock in data mode");
   chk_ref_lock_freq: assert property ((cfg_manual_lock && cfg_mode != 2'h2 && reference_lock_mode[0]
      && !data_lock_mode[0]) [*2] |-> !rx_freqlocked[0]) else $error("freq lock in reference mode");
endmodule

/* trlc_ctl.sv */
// Fabric reset controller with APB control and status registers
`timescale 1ns/10ps
module trlc_ctl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             seq_done,
   trlc_if.ctl              lnk
);
   // ===================================================================
   // Types
   typedef enum logic [8:0]
   {
      H_IDLE    = 9'h001,
      H_PLL_PD  = 9'h002,
      H_TX_LOCK = 9'h004,
      H_BUSY    = 9'h008,
      H_ANA     = 9'h010,
      H_LOCK    = 9'h020,
      H_REF     = 9'h040,
      H_DIG     = 9'h080,
      H_DONE    = 9'h100
   } trlc_seq_type;

   typedef struct packed
   {
      trlc_seq_type                st;
      logic [trlc_pkg::CNT_W-1:0]  cnt;
      logic [31:0]                 ctrl;
      logic                        busy_prev;
      logic                        busy_done;
      logic [trlc_pkg::NUM_CH-1:0] tx_rst;
      logic [trlc_pkg::NUM_CH-1:0] rx_rst;
      logic [trlc_pkg::NUM_CH-1:0] ana_rst;
      logic [trlc_pkg::NUM_CH-1:0] ref_sel;
      logic [trlc_pkg::NUM_CH-1:0] data_sel;
      logic                        pll_pd;
      logic [31:0]                 prdata;
      logic                        pready;
      logic                        pslverr;
      logic                        done;
   } trlc_ctl_type;

   trlc_ctl_type s_reg;
   trlc_ctl_type s_next;
   logic         wr_ctrl;
   logic         manual;

   // ===================================================================
   // Next state
   always_comb
   begin
      s_next         = s_reg;
      wr_ctrl        = psel & penable & s_reg.pready & pwrite & (paddr == trlc_pkg::CTRL_OFFSET);
      manual         = s_reg.ctrl[trlc_pkg::CTRL_MANUAL_BIT] &
                       (s_reg.ctrl[trlc_pkg::CTRL_MODE_LSB +: 2] != trlc_pkg::MODE_PCIE);
      // Zero-wait slave: ready in the first access cycle
      s_next.pready  = psel & ~penable;
      s_next.pslverr = psel & ~penable & (paddr != trlc_pkg::CTRL_OFFSET) & (paddr != trlc_pkg::STAT_OFFSET);
      s_next.prdata  = '0;
      if (psel & ~penable & (paddr == trlc_pkg::CTRL_OFFSET))
      begin
         s_next.prdata = s_reg.ctrl;
      end
      else if (psel & ~penable & (paddr == trlc_pkg::STAT_OFFSET))
      begin
         s_next.prdata[trlc_pkg::STAT_DONE_BIT]              = s_reg.done;
         s_next.prdata[trlc_pkg::STAT_BUSY_BIT]              = lnk.busy;
         s_next.prdata[trlc_pkg::STAT_PLL_BIT]               = lnk.pll_locked;
         s_next.prdata[trlc_pkg::STAT_FREQ_BIT]              = &lnk.rx_freqlocked;
         s_next.prdata[trlc_pkg::STAT_REFL_BIT]              = &lnk.rx_pll_locked;
         s_next.prdata[trlc_pkg::STAT_STATE_LSB +: 9]        = s_reg.st;
      end

      // Busy is watched from reset so a fall before start is not missed
      s_next.busy_prev = lnk.busy;
      if (s_reg.busy_prev & ~lnk.busy)
      begin
         s_next.busy_done = 1'b1;
      end

      if (wr_ctrl)
      begin
         s_next.ctrl = pwdata & 32'h0000_007e;
      end

      case (s_reg.st)
         H_IDLE:
         begin
         end
         H_PLL_PD:
         begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt == trlc_pkg::PD_CYCLES - 1'b1)
            begin
               s_next.pll_pd = 1'b0;
               s_next.st     = H_TX_LOCK;
            end
         end
         H_TX_LOCK:
         begin
            if (lnk.pll_locked)
            begin
               s_next.tx_rst = '0;
               // Transmitter-only setups skip busy
               s_next.st     = s_reg.ctrl[trlc_pkg::CTRL_HAS_RX_BIT] ? H_BUSY : H_DONE;
            end
         end
         H_BUSY:
         begin
            s_next.cnt = '0;
            if (s_reg.busy_done)
            begin
               s_next.st = H_ANA;
            end
         end
         H_ANA:
         begin
            // Analog reset has been held since start, well over two cycles
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt == trlc_pkg::ANA_WAIT_CYCLES - 1'b1)
            begin
               s_next.ana_rst = '0;
               s_next.st      = H_LOCK;
            end
         end
         H_LOCK:
         begin
            s_next.cnt = '0;
            if (manual & (&lnk.rx_pll_locked))
            begin
               s_next.st = H_REF;
            end
            else if (~manual & (&lnk.rx_freqlocked))
            begin
               // PCIe lands here: automatic lock, no manual hand-over
               s_next.st = H_DIG;
            end
         end
         H_REF:
         begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt == trlc_pkg::REF_CYCLES - 1'b1)
            begin
               s_next.ref_sel  = '0;
               s_next.data_sel = '1;
               s_next.cnt      = '0;
               s_next.st       = H_DIG;
            end
         end
         H_DIG:
         begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt == trlc_pkg::DIG_CYCLES - 1'b1)
            begin
               s_next.rx_rst = '0;
               s_next.st     = H_DONE;
            end
         end
         H_DONE:
         begin
            s_next.done = 1'b1;
         end
         default:
         begin
            s_next.st = H_IDLE;
         end
      endcase

      // Start restarts the whole sequence from any state
      if (wr_ctrl & pwdata[trlc_pkg::CTRL_START_BIT])
      begin
         s_next.st       = H_PLL_PD;
         s_next.cnt      = '0;
         s_next.done     = 1'b0;
         s_next.pll_pd   = 1'b1;
         s_next.tx_rst   = '1;
         s_next.rx_rst   = '1;
         s_next.ana_rst  = '1;
         s_next.ref_sel  = pwdata[trlc_pkg::CTRL_MANUAL_BIT] ? '1 : '0;
         s_next.data_sel = '0;
      end
   end

   // ===================================================================
   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg         <= '0;
         s_reg.st      <= H_IDLE;
         s_reg.ctrl    <= trlc_pkg::CTRL_RESET;
         s_reg.tx_rst  <= '1;
         s_reg.rx_rst  <= '1;
         s_reg.ana_rst <= '1;
         s_reg.pll_pd  <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ===================================================================
   // Outputs
   assign prdata                  = s_reg.prdata;
   assign pready                  = s_reg.pready;
   assign pslverr                 = s_reg.pslverr;
   assign seq_done                = s_reg.done;
   assign lnk.tx_digital_reset    = s_reg.tx_rst;
   assign lnk.rx_digital_reset    = s_reg.rx_rst;
   assign lnk.rx_analog_reset     = s_reg.ana_rst;
   assign lnk.pll_powerdown       = s_reg.pll_pd;
   assign lnk.block_powerdown     = s_reg.ctrl[trlc_pkg::CTRL_BLK_PD_BIT];
   assign lnk.reference_lock_mode = s_reg.ref_sel;
   assign lnk.data_lock_mode      = s_reg.data_sel;
   assign lnk.cfg_mode            = s_reg.ctrl[trlc_pkg::CTRL_MODE_LSB +: 2];
   // Four-lane attachment mode is always driven as bonded
   assign lnk.cfg_bonded          = s_reg.ctrl[trlc_pkg::CTRL_BONDED_BIT] |
                                    (s_reg.ctrl[trlc_pkg::CTRL_MODE_LSB +: 2] == trlc_pkg::MODE_XAUI);
   assign lnk.cfg_has_rx          = s_reg.ctrl[trlc_pkg::CTRL_HAS_RX_BIT];
   assign lnk.cfg_manual_lock     = s_reg.ctrl[trlc_pkg::CTRL_MANUAL_BIT];
endmodule

/* trlc_if.sv */
// Link between the transceiver end and the fabric reset controller
`timescale 1ns/10ps
interface trlc_if;
   logic [trlc_pkg::NUM_CH-1:0] tx_digital_reset;
   logic [trlc_pkg::NUM_CH-1:0] rx_digital_reset;
   logic [trlc_pkg::NUM_CH-1:0] rx_analog_reset;
   logic                        pll_powerdown;
   logic                        block_powerdown;
   logic [trlc_pkg::NUM_CH-1:0] reference_lock_mode;
   logic [trlc_pkg::NUM_CH-1:0] data_lock_mode;
   logic [1:0]                  cfg_mode;
   logic                        cfg_bonded;
   logic                        cfg_has_rx;
   logic                        cfg_manual_lock;
   logic                        busy;
   logic                        pll_locked;
   logic [trlc_pkg::NUM_CH-1:0] rx_pll_locked;
   logic [trlc_pkg::NUM_CH-1:0] rx_freqlocked;

   modport dev (
      input  tx_digital_reset, rx_digital_reset, rx_analog_reset, pll_powerdown, block_powerdown,
      input  reference_lock_mode, data_lock_mode, cfg_mode, cfg_bonded, cfg_has_rx, cfg_manual_lock,
      output busy, pll_locked, rx_pll_locked, rx_freqlocked
   );
   modport ctl (
      output tx_digital_reset, rx_digital_reset, rx_analog_reset, pll_powerdown, block_powerdown,
      output reference_lock_mode, data_lock_mode, cfg_mode, cfg_bonded, cfg_has_rx, cfg_manual_lock,
      input  busy, pll_locked, rx_pll_locked, rx_freqlocked
   );
endinterface

/* trlc_pkg.sv */
// Constants, codes and timing for the transceiver reset and lock control pair
// ======================================================================
// Contract
// - Transmit digital reset clears transmit PCS only
// - Receive resets clear PCS or recovery circuit only
// - Receiver present keeps offset cancellation controller active
// - Reset logic always watches busy with receivers
// - Busy low in first cycle after start-up
// - Busy high from second cycle during cancellation; here busy rises one cycle after the receiver bit is set
// - Busy falls when offset cancellation completes
// - Wait on busy unless transmitter-only configuration
// - Four-lane attachment mode must be bonded
// - PCIe mode uses its own reset sequence; here it runs the automatic-lock sequence of the other modes
// - Non-PCIe modes offer automatic and manual lock
// - Manual lock follows the two select inputs
// - Data select wins; both low means automatic
// - Bonded four-lane group resets as one
// - Reset logic follows documented sequences
// - Analog reset held at least two cycles
// - PLL lock output high while PLL locked
// - Frequency lock high in data mode only
package trlc_pkg;
   // ===================================================================
   // Sizes
   localparam int NUM_CH = 4;
   localparam int CNT_W  = 10;

   // ===================================================================
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int PD_TIME_NS    = 1000;
   localparam int REF_TIME_NS   = 15000;
   localparam int DIG_TIME_NS   = 4000;
   localparam logic [CNT_W-1:0] PD_CYCLES  = CNT_W'((PD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] REF_CYCLES = CNT_W'((REF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] DIG_CYCLES = CNT_W'((DIG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] ANA_WAIT_CYCLES     = 10'h002;
   // Device-side model figures, plain defaults
   localparam logic [CNT_W-1:0] OC_CYCLES           = 10'h040;
   localparam logic [CNT_W-1:0] TX_PLL_LOCK_CYCLES  = 10'h028;
   localparam logic [CNT_W-1:0] CDR_REF_LOCK_CYCLES = 10'h01e;
   localparam logic [CNT_W-1:0] CDR_DATA_CYCLES     = 10'h010;

   // ===================================================================
   // Functional modes
   localparam logic [1:0] MODE_BASIC = 2'h0;
   localparam logic [1:0] MODE_XAUI  = 2'h1;
   localparam logic [1:0] MODE_PCIE  = 2'h2;

   // ===================================================================
   // Controller registers
   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] STAT_OFFSET = 12'h004;
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
   localparam int CTRL_START_BIT   = 0;
   localparam int CTRL_HAS_RX_BIT  = 1;
   localparam int CTRL_MANUAL_BIT  = 2;
   localparam int CTRL_BONDED_BIT  = 3;
   localparam int CTRL_MODE_LSB    = 4;
   localparam int CTRL_BLK_PD_BIT  = 6;
   localparam int STAT_DONE_BIT    = 0;
   localparam int STAT_BUSY_BIT    = 1;
   localparam int STAT_PLL_BIT     = 2;
   localparam int STAT_FREQ_BIT    = 3;
   localparam int STAT_REFL_BIT    = 4;
   localparam int STAT_STATE_LSB   = 8;
endpackage

/* trlc_xcvr.sv */
// Transceiver end: reset domains, offset cancellation busy and lock status
`timescale 1ns/10ps
module trlc_xcvr (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   trlc_if.dev                              lnk,
   output logic [trlc_pkg::NUM_CH-1:0]      tx_pcs_reset,
   output logic [trlc_pkg::NUM_CH-1:0]      rx_pcs_reset,
   output logic [trlc_pkg::NUM_CH-1:0]      cdr_reset,
   output logic                             cmu_pll_off,
   output logic                             tx_buffer_off,
   output logic                             rx_buffer_off,
   output logic                             deser_off,
   output logic                             offset_cancel_active,
   output logic                             cfg_error
);
   // ===================================================================
   // Types
   typedef enum logic [2:0]
   {
      OC_FIRST = 3'h1,
      OC_RUN   = 3'h2,
      OC_DONE  = 3'h4
   } trlc_oc_type;

   typedef struct packed
   {
      trlc_oc_type                                      oc;
      logic [trlc_pkg::CNT_W-1:0]                       oc_cnt;
      logic                                             busy;
      logic [trlc_pkg::CNT_W-1:0]                       pll_cnt;
      logic                                             pll_locked;
      logic [trlc_pkg::NUM_CH-1:0][trlc_pkg::CNT_W-1:0] cdr_cnt;
      logic [trlc_pkg::NUM_CH-1:0]                      in_data;
      logic [trlc_pkg::NUM_CH-1:0]                      ref_locked;
      logic [trlc_pkg::NUM_CH-1:0]                      tx_pcs_reset;
      logic [trlc_pkg::NUM_CH-1:0]                      rx_pcs_reset;
      logic [trlc_pkg::NUM_CH-1:0]                      cdr_reset;
      logic                                             cmu_pll_off;
      logic                                             tx_buffer_off;
      logic                                             rx_buffer_off;
      logic                                             deser_off;
      logic                                             oc_active;
      logic                                             cfg_error;
   } trlc_dev_type;

   trlc_dev_type s_reg;
   trlc_dev_type s_next;

   logic                        bonded;
   logic                        manual;
   logic                        blk_pd;
   logic [trlc_pkg::NUM_CH-1:0] tx_rst;
   logic [trlc_pkg::NUM_CH-1:0] rx_rst;
   logic [trlc_pkg::NUM_CH-1:0] ana_rst;
   logic [trlc_pkg::NUM_CH-1:0] ref_sel;
   logic [trlc_pkg::NUM_CH-1:0] data_sel;

   // ===================================================================
   // Next state
   always_comb
   begin
      s_next = s_reg;
      blk_pd = lnk.block_powerdown;
      bonded = lnk.cfg_bonded | (lnk.cfg_mode == trlc_pkg::MODE_XAUI);
      // Manual lock is a configuration choice, never in PCIe mode
      manual = lnk.cfg_manual_lock & (lnk.cfg_mode != trlc_pkg::MODE_PCIE);

      // Bonded group follows lane 0 so all four reset together
      if (bonded)
      begin
         tx_rst   = {trlc_pkg::NUM_CH{lnk.tx_digital_reset[0]}};
         rx_rst   = {trlc_pkg::NUM_CH{lnk.rx_digital_reset[0]}};
         ana_rst  = {trlc_pkg::NUM_CH{lnk.rx_analog_reset[0]}};
         ref_sel  = {trlc_pkg::NUM_CH{lnk.reference_lock_mode[0]}};
         data_sel = {trlc_pkg::NUM_CH{lnk.data_lock_mode[0]}};
      end
      else
      begin
         tx_rst   = lnk.tx_digital_reset;
         rx_rst   = lnk.rx_digital_reset;
         ana_rst  = lnk.rx_analog_reset;
         ref_sel  = lnk.reference_lock_mode;
         data_sel = lnk.data_lock_mode;
      end
      // Unbonded four-lane mode is illegal; flagged, then forced bonded
      s_next.cfg_error = (lnk.cfg_mode == trlc_pkg::MODE_XAUI) & ~lnk.cfg_bonded;

      // Reset domains; buffers and deserializer only follow block power-down
      s_next.tx_pcs_reset  = tx_rst | {trlc_pkg::NUM_CH{blk_pd}};
      s_next.rx_pcs_reset  = rx_rst | {trlc_pkg::NUM_CH{blk_pd}};
      s_next.cdr_reset     = ana_rst | {trlc_pkg::NUM_CH{blk_pd}};
      s_next.cmu_pll_off   = lnk.pll_powerdown | blk_pd;
      s_next.tx_buffer_off = blk_pd;
      s_next.rx_buffer_off = blk_pd;
      s_next.deser_off     = blk_pd;

      // Transmit PLL lock model
      if (lnk.pll_powerdown | blk_pd)
      begin
         s_next.pll_cnt = '0;
      end
      else if (s_reg.pll_cnt != trlc_pkg::TX_PLL_LOCK_CYCLES)
      begin
         s_next.pll_cnt = s_reg.pll_cnt + 1'b1;
      end
      s_next.pll_locked = (s_next.pll_cnt == trlc_pkg::TX_PLL_LOCK_CYCLES);

      // Offset cancellation; runs once after start-up when a receiver exists
      s_next.oc_active = lnk.cfg_has_rx;
      case (s_reg.oc)
         OC_FIRST:
         begin
            // Busy stayed low through the first cycle
            s_next.oc_cnt = '0;
            if (lnk.cfg_has_rx)
            begin
               s_next.oc   = OC_RUN;
               s_next.busy = 1'b1;
            end
            else
            begin
               // Receiver set up later by software; cancellation waits for it
               s_next.oc   = OC_FIRST;
               s_next.busy = 1'b0;
            end
         end
         OC_RUN:
         begin
            s_next.oc_cnt = s_reg.oc_cnt + 1'b1;
            if (s_reg.oc_cnt == trlc_pkg::OC_CYCLES - 1'b1)
            begin
               s_next.oc   = OC_DONE;
               s_next.busy = 1'b0;
            end
         end
         OC_DONE:
         begin
            s_next.busy = 1'b0;
         end
         default:
         begin
            s_next.oc   = OC_DONE;
            s_next.busy = 1'b0;
         end
      endcase

      // Recovery circuit per channel
      for (int i = 0; i < trlc_pkg::NUM_CH; i++)
      begin
         if (s_next.cdr_reset[i] | ~lnk.cfg_has_rx)
         begin
            s_next.cdr_cnt[i]    = '0;
            s_next.in_data[i]    = 1'b0;
            s_next.ref_locked[i] = 1'b0;
         end
         else if (manual & data_sel[i])
         begin
            // Data select wins over reference select
            s_next.in_data[i]    = 1'b1;
            s_next.ref_locked[i] = 1'b0;
            s_next.cdr_cnt[i]    = '0;
         end
         else if (manual & ref_sel[i])
         begin
            s_next.in_data[i] = 1'b0;
            // Locking waits for the PLL and for cancellation to finish
            if (s_reg.pll_locked & ~s_reg.busy & (s_reg.cdr_cnt[i] != trlc_pkg::CDR_REF_LOCK_CYCLES))
            begin
               s_next.cdr_cnt[i] = s_reg.cdr_cnt[i] + 1'b1;
            end
            s_next.ref_locked[i] = (s_next.cdr_cnt[i] == trlc_pkg::CDR_REF_LOCK_CYCLES);
         end
         else
         begin
            // Automatic: lock to reference, then hand over to data
            s_next.ref_locked[i] = 1'b0;
            if (~s_reg.in_data[i] & s_reg.pll_locked & ~s_reg.busy)
            begin
               s_next.cdr_cnt[i] = s_reg.cdr_cnt[i] + 1'b1;
               if (s_reg.cdr_cnt[i] == trlc_pkg::CDR_REF_LOCK_CYCLES + trlc_pkg::CDR_DATA_CYCLES)
               begin
                  s_next.in_data[i] = 1'b1;
               end
            end
         end
      end
   end

   // ===================================================================
   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg               <= '0;
         s_reg.oc            <= OC_FIRST;
         s_reg.tx_pcs_reset  <= '1;
         s_reg.rx_pcs_reset  <= '1;
         s_reg.cdr_reset     <= '1;
         s_reg.cmu_pll_off   <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ===================================================================
   // Outputs
   assign lnk.busy             = s_reg.busy;
   assign lnk.pll_locked       = s_reg.pll_locked;
   assign lnk.rx_pll_locked    = s_reg.ref_locked;
   assign lnk.rx_freqlocked    = s_reg.in_data;
   assign tx_pcs_reset         = s_reg.tx_pcs_reset;
   assign rx_pcs_reset         = s_reg.rx_pcs_reset;
   assign cdr_reset            = s_reg.cdr_reset;
   assign cmu_pll_off          = s_reg.cmu_pll_off;
   assign tx_buffer_off        = s_reg.tx_buffer_off;
   assign rx_buffer_off        = s_reg.rx_buffer_off;
   assign deser_off            = s_reg.deser_off;
   assign offset_cancel_active = s_reg.oc_active;
   assign cfg_error            = s_reg.cfg_error;
endmodule
